// >>> include/psf_pkg.sv
`default_nettype none
package psf_pkg;
   // register offsets (low address byte)
   localparam logic [7:0] PSF_OFS_PAGE_CONTROL = 8'h00;
   localparam logic [7:0] PSF_OFS_RAMP_KEY     = 8'h01;
   localparam logic [7:0] PSF_OFS_INPUT_LEVELS = 8'h02;
   localparam logic [7:0] PSF_OFS_OVERCURRENT  = 8'h04;
   localparam logic [7:0] PSF_OFS_SHUTDOWN_LOG = 8'h05;
   // page_control fields
   localparam int PSF_AUTO_RETURN_BIT = 7;
   localparam int PSF_WMODE_BIT  = 6;
   localparam int PSF_PAGE_MSB   = 5;
   // status_ramp_key fields
   localparam int PSF_RAMP_BIT = 2;
   localparam int PSF_KEY_BIT  = 0;
   // shutdown_cause_log fields
   localparam int PSF_LOG_WAIT  = 7;
   localparam int PSF_LOG_RREQ  = 6;
   localparam int PSF_LOG_KEY   = 5;
   localparam int PSF_LOG_TEMP  = 4;
   localparam int PSF_LOG_START = 3;
   localparam int PSF_LOG_LOWUV = 2;
   localparam int PSF_LOG_POR   = 1;
   localparam int PSF_LOG_WDG   = 0;
   // reset values
   localparam logic [7:0] PSF_PAGE_CONTROL_RST = 8'h00;
   localparam logic [7:0] PSF_SHUTDOWN_LOG_RST = 8'h00;
   localparam logic [7:0] PSF_PIN_SYNC_RST     = 8'hFF;
   // timing
   localparam longint PSF_CLK_HZ             = 250_000_000;
   localparam longint PSF_VDD_START_WINDOW_S = 16;
   localparam longint PSF_VDD_START_CYCLES   = PSF_VDD_START_WINDOW_S * PSF_CLK_HZ;
   // bus slave address; value is arbitrary
   localparam logic [6:0] PSF_DEV_ADDR_DEFAULT = 7'h5A;
   typedef enum logic [2:0] {
      PSF_IDLE = 3'b000,
      PSF_RX   = 3'b001,
      PSF_ACK  = 3'b010,
      PSF_TX   = 3'b011,
      PSF_RACK = 3'b100
   } psf_bus_st_t;
   typedef enum logic [1:0] {
      PSF_CTX_ADDR = 2'b00,
      PSF_CTX_REG  = 2'b01,
      PSF_CTX_DATA = 2'b10
   } psf_ctx_t;
endpackage
`default_nettype wire

// >>> rtl/psf_fault_log.sv
`timescale 1ns/1ns
`default_nettype none
module psf_fault_log
   import psf_pkg::*;
#(
   parameter logic [31:0] VDD_START_CYCLES = 32'(PSF_VDD_START_CYCLES)
) (
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   input  wire logic       wait_step_timeout,
   input  wire logic       reset_request_pd,
   input  wire logic       power_key_reset,
   input  wire logic       critical_overtemp,
   input  wire logic       supply_start_uv,
   input  wire logic       supply_lower_uv,
   input  wire logic       power_on_start,
   input  wire logic       watchdog_expiry,
   input  wire logic       system_reset_out_n,
   input  wire logic       clr_we,
   input  wire logic [7:0] clr_data,
   output logic      [7:0] log_q
);
   typedef struct packed {
      logic [7:0]  log;
      logic [31:0] cnt;
   } psf_log_st_t;

   psf_log_st_t r;
   psf_log_st_t next_r;
   logic [7:0]  set;
   logic [7:0]  clr_mask;
   logic        early;

   if (VDD_START_CYCLES == 32'h0) begin : g_chk
      $error("psf_fault_log: window must be at least one cycle");
   end

   // window timer runs from release of the system reset output
   always_comb begin
      next_r = r;
      early  = !system_reset_out_n || (r.cnt < VDD_START_CYCLES);
      if (!system_reset_out_n) begin
         next_r.cnt = 32'h0;
      end else if (r.cnt != VDD_START_CYCLES) begin
         next_r.cnt = r.cnt + 32'h1;
      end
      set                = 8'h00;
      set[PSF_LOG_WAIT]  = wait_step_timeout;
      set[PSF_LOG_RREQ]  = reset_request_pd;
      set[PSF_LOG_KEY]   = power_key_reset;
      set[PSF_LOG_TEMP]  = critical_overtemp;
      set[PSF_LOG_START] = supply_start_uv && early;
      set[PSF_LOG_LOWUV] = supply_lower_uv;
      set[PSF_LOG_POR]   = power_on_start;
      set[PSF_LOG_WDG]   = watchdog_expiry;
      clr_mask           = clr_we ? clr_data : 8'h00;
      // set beats a clear in the same cycle so no event is lost
      next_r.log         = (r.log & ~clr_mask) | set;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         r.log <= PSF_SHUTDOWN_LOG_RST;
         r.cnt <= 32'h0;
      end else begin
         r <= next_r;
      end
   end

   assign log_q = r.log;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   a_wait_sets: assert property (wait_step_timeout |=> log_q[PSF_LOG_WAIT])
      else $error("wait timeout not logged");
   a_rreq_sets: assert property (reset_request_pd |=> log_q[PSF_LOG_RREQ])
      else $error("reset request not logged");
   a_key_temp: assert property ((power_key_reset || critical_overtemp)
      |=> (log_q[PSF_LOG_KEY] || !$past(power_key_reset))
      && (log_q[PSF_LOG_TEMP] || !$past(critical_overtemp)))
      else $error("key or temp not logged");
   a_late_uv: assert property ((supply_start_uv && system_reset_out_n
      && r.cnt >= VDD_START_CYCLES && !log_q[PSF_LOG_START] && !early)
      |=> !log_q[PSF_LOG_START])
      else $error("late under-voltage logged");
   a_log_holds: assert property (1'b1 |=>
      (($past(log_q) & ~$past(clr_mask)) & ~log_q) == 8'h00)
      else $error("log bit lost without clear");
   a_clear_ok: assert property ((clr_we && set == 8'h00)
      |=> (log_q & $past(clr_data)) == 8'h00)
      else $error("written one did not clear");
endmodule // psf_fault_log
`default_nettype wire

// >>> rtl/psf_page_status_fault.sv
`timescale 1ns/1ns
`default_nettype none
module psf_page_status_fault
   import psf_pkg::*;
#(
   parameter logic [6:0]  DEV_ADDR         = PSF_DEV_ADDR_DEFAULT,
   parameter logic [31:0] VDD_START_CYCLES = 32'(PSF_VDD_START_CYCLES)
) (
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   input  wire logic       power_key_pin_n,
   input  wire logic [4:0] gpi_pin,
   input  wire logic       voltage_ramp_active,
   input  wire logic [3:0] regulator_overcurrent_flag,
   input  wire logic       wait_step_timeout,
   input  wire logic       external_reset_request,
   input  wire logic       power_key_reset,
   input  wire logic       critical_overtemp,
   input  wire logic       system_supply_start_uv,
   input  wire logic       system_supply_lower_uv,
   input  wire logic       power_on_start,
   input  wire logic       watchdog_expiry,
   input  wire logic       system_reset_out_n,
   output logic      [5:0] page_sel,
   output logic      [7:0] shutdown_cause_log
);
   typedef struct packed {
      psf_bus_st_t st;
      psf_ctx_t    ctx;
      logic [3:0]  cnt;
      logic [7:0]  sh;
      logic        rw;
      logic [7:0]  ptr;
      logic        drv;
      logic [5:0]  page;
      logic        wmode;
      logic        page_auto_return;
      logic        scl_q;
      logic        sda_q;
      logic        clr_we;
      logic [7:0]  clr_data;
   } psf_main_st_t;

   psf_main_st_t r;
   psf_main_st_t next_r;
   logic [7:0]   pins;
   logic         scl_f;
   logic         sda_f;
   logic         key_level;
   logic [4:0]   gpi_level;
   logic         scl_rise;
   logic         scl_fall;
   logic         start_c;
   logic         stop_c;
   logic         wr_en;
   logic         load;
   logic         access;
   logic [7:0]   rd_byte;

   // page bit zero takes no part in the decode from the bus
   function automatic logic psf_low_page(input logic [5:0] pg);
      return pg[PSF_PAGE_MSB:1] == 5'h00;
   endfunction

   // pins from outside pass the three-stage filter
   psf_pin_sync #(
      .W       (8),
      .RST_VAL (PSF_PIN_SYNC_RST)
   ) u_sync (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .din     ({gpi_pin, power_key_pin_n, sda_in, scl_in}),
      .dout    (pins)
   );

   assign scl_f     = pins[0];
   assign sda_f     = pins[1];
   assign key_level = pins[2];
   assign gpi_level = pins[7:3];

   psf_fault_log #(
      .VDD_START_CYCLES (VDD_START_CYCLES)
   ) u_log (
      .sys_clk            (sys_clk),
      .nrst               (nrst),
      .wait_step_timeout  (wait_step_timeout),
      .reset_request_pd   (external_reset_request),
      .power_key_reset    (power_key_reset),
      .critical_overtemp  (critical_overtemp),
      .supply_start_uv    (system_supply_start_uv),
      .supply_lower_uv    (system_supply_lower_uv),
      .power_on_start     (power_on_start),
      .watchdog_expiry    (watchdog_expiry),
      .system_reset_out_n (system_reset_out_n),
      .clr_we             (r.clr_we),
      .clr_data           (r.clr_data),
      .log_q              (shutdown_cause_log)
   );

   // bus line events on the filtered levels
   assign scl_rise = scl_f & ~r.scl_q;
   assign scl_fall = ~scl_f & r.scl_q;
   assign start_c  = scl_f & r.scl_q & r.sda_q & ~sda_f;
   assign stop_c   = scl_f & r.scl_q & ~r.sda_q & sda_f;

   // read mux; status bits are live, nothing latched here
   always_comb begin
      rd_byte = 8'h00;
      if (r.ptr == PSF_OFS_PAGE_CONTROL) begin
         rd_byte = {r.page_auto_return, r.wmode, r.page};
      end else if (psf_low_page(r.page)) begin
         unique case (r.ptr)
            PSF_OFS_RAMP_KEY: begin
               rd_byte[PSF_RAMP_BIT] = voltage_ramp_active;
               rd_byte[PSF_KEY_BIT]  = key_level;
            end
            PSF_OFS_INPUT_LEVELS: rd_byte = {3'h0, gpi_level};
            PSF_OFS_OVERCURRENT:  rd_byte = {4'h0, regulator_overcurrent_flag};
            PSF_OFS_SHUTDOWN_LOG: rd_byte = shutdown_cause_log;
            default:           rd_byte = 8'h00;
         endcase
      end
   end

   // serial slave and register side effects
   always_comb begin
      next_r        = r;
      next_r.scl_q  = scl_f;
      next_r.sda_q  = sda_f;
      next_r.clr_we = 1'b0;
      wr_en         = 1'b0;
      load          = 1'b0;
      if (start_c) begin
         next_r.st  = PSF_RX;
         next_r.ctx = PSF_CTX_ADDR;
         next_r.cnt = 4'h0;
         next_r.drv = 1'b0;
      end else if (stop_c) begin
         next_r.st  = PSF_IDLE;
         next_r.drv = 1'b0;
      end else begin
         unique case (r.st)
            PSF_IDLE: begin
               next_r.drv = 1'b0;
            end
            PSF_RX: begin
               if (scl_rise) begin
                  next_r.sh  = {r.sh[6:0], sda_f};
                  next_r.cnt = r.cnt + 4'h1;
               end else if (scl_fall && r.cnt == 4'h8) begin
                  next_r.cnt = 4'h0;
                  next_r.st  = PSF_ACK;
                  next_r.drv = 1'b1;
                  unique case (r.ctx)
                     PSF_CTX_ADDR: begin
                        if (r.sh[7:1] == DEV_ADDR) begin
                           next_r.rw  = r.sh[0];
                           next_r.ctx = PSF_CTX_REG;
                        end else begin
                           // not ours: stay off the line until a new start
                           next_r.st  = PSF_IDLE;
                           next_r.drv = 1'b0;
                        end
                     end
                     PSF_CTX_REG: begin
                        next_r.ptr = r.sh;
                        next_r.ctx = PSF_CTX_DATA;
                     end
                     default: begin
                        wr_en = 1'b1;
                        if (r.wmode) begin
                           next_r.ctx = PSF_CTX_REG;
                        end else begin
                           next_r.ptr = r.ptr + 8'h01;
                        end
                     end
                  endcase
               end
            end
            PSF_ACK: begin
               if (scl_fall) begin
                  next_r.drv = 1'b0;
                  if (r.rw) begin
                     load = 1'b1;
                  end else begin
                     next_r.st = PSF_RX;
                  end
               end
            end
            PSF_TX: begin
               if (scl_rise) begin
                  next_r.cnt = r.cnt + 4'h1;
               end else if (scl_fall) begin
                  if (r.cnt == 4'h8) begin
                     next_r.drv = 1'b0;
                     next_r.cnt = 4'h0;
                     next_r.st  = PSF_RACK;
                  end else begin
                     next_r.drv = ~r.sh[7];
                     next_r.sh  = {r.sh[6:0], 1'b0};
                  end
               end
            end
            PSF_RACK: begin
               // a high ninth bit is the master's nack: end of read
               if (scl_rise && sda_f) begin
                  next_r.st = PSF_IDLE;
               end else if (scl_fall) begin
                  load = 1'b1;
               end
            end
            default: begin
               next_r.st  = PSF_IDLE;
               next_r.drv = 1'b0;
            end
         endcase
      end
      // fetch a read byte and drive its top bit at once
      if (load) begin
         next_r.st  = PSF_TX;
         next_r.cnt = 4'h0;
         next_r.sh  = {rd_byte[6:0], 1'b0};
         next_r.drv = ~rd_byte[7];
         next_r.ptr = r.ptr + 8'h01;
      end
      access = wr_en | load;
      // auto-return: page control access itself does not count
      if (access && r.page_auto_return && r.ptr != PSF_OFS_PAGE_CONTROL) begin
         next_r.page = 6'h00;
      end
      // status registers have no write path at all
      if (wr_en && r.ptr == PSF_OFS_PAGE_CONTROL) begin
         next_r.page_auto_return = r.sh[PSF_AUTO_RETURN_BIT];
         next_r.wmode  = r.sh[PSF_WMODE_BIT];
         next_r.page   = r.sh[PSF_PAGE_MSB:0];
      end else if (wr_en && psf_low_page(r.page) && r.ptr == PSF_OFS_SHUTDOWN_LOG) begin
         next_r.clr_we   = 1'b1;
         next_r.clr_data = r.sh;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         r          <= '0;
         r.st       <= PSF_IDLE;
         r.ctx      <= PSF_CTX_ADDR;
         r.page_auto_return <= PSF_PAGE_CONTROL_RST[PSF_AUTO_RETURN_BIT];
         r.wmode    <= PSF_PAGE_CONTROL_RST[PSF_WMODE_BIT];
         r.page     <= PSF_PAGE_CONTROL_RST[PSF_PAGE_MSB:0];
         r.scl_q    <= 1'b1;
         r.sda_q    <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // open drain: only ever pull low
   assign sda_out  = 1'b0;
   assign sda_oe_n = ~r.drv;
   assign page_sel = r.page;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   a_stop_idle: assert property (stop_c |=> r.st == PSF_IDLE && sda_oe_n)
      else $error("stop did not release the bus");
   a_page_return: assert property ((access && r.page_auto_return && !(wr_en
      && r.ptr == PSF_OFS_PAGE_CONTROL) && r.ptr != PSF_OFS_PAGE_CONTROL)
      |=> page_sel == 6'h00)
      else $error("page did not return to zero");
   a_pair_mode: assert property ((wr_en && r.wmode) |=> r.ctx == PSF_CTX_REG)
      else $error("pair mode did not expect an address");
   a_inc_mode: assert property ((wr_en && !r.wmode)
      |=> r.ptr == $past(r.ptr) + 8'h01 && r.ctx == PSF_CTX_DATA)
      else $error("sequential write did not advance");
   a_page_bit0: assert property ((load && r.page[0] && r.page[5:1] == 5'h00
      && r.ptr == PSF_OFS_SHUTDOWN_LOG)
      |=> r.sh[7:1] == $past(shutdown_cause_log[6:0]))
      else $error("page bit zero changed the decode");
   a_status_live: assert property ((load && psf_low_page(r.page)
      && r.ptr == PSF_OFS_RAMP_KEY)
      |=> r.sh[3] == $past(voltage_ramp_active) && r.sh[1] == $past(key_level))
      else $error("ramp or key status wrong");
   a_ocp_status: assert property ((load && psf_low_page(r.page)
      && r.ptr == PSF_OFS_OVERCURRENT)
      |=> r.sh[4:1] == $past(regulator_overcurrent_flag) && r.sh[7:5] == 3'h0)
      else $error("overcurrent status wrong");
   a_ro_write: assert property ((wr_en && r.ptr != PSF_OFS_PAGE_CONTROL
      && r.ptr != PSF_OFS_SHUTDOWN_LOG) |=> !r.clr_we)
      else $error("status write had an effect");
endmodule // psf_page_status_fault
`default_nettype wire

// >>> rtl/psf_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module psf_pin_sync
   import psf_pkg::*;
#(
   parameter int         W       = 8,
   parameter logic [7:0] RST_VAL = PSF_PIN_SYNC_RST
) (
   input  wire logic         sys_clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } psf_sync_st_t;

   psf_sync_st_t r;
   psf_sync_st_t next_r;

   if (W < 1 || W > 8) begin : g_chk
      $error("psf_pin_sync: W must be 1..8");
   end

   // s1 feeds s2 only; a change is taken once s2 and s3 agree
   always_comb begin
      next_r     = r;
      next_r.s1  = din;
      next_r.s2  = r.s1;
      next_r.s3  = r.s2;
      next_r.lvl = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.lvl);
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         r <= {4{RST_VAL[W-1:0]}};
      end else begin
         r <= next_r;
      end
   end

   assign dout = r.lvl;
endmodule // psf_pin_sync
`default_nettype wire

// >>> verif/psf_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module psf_host_model (
   input  wire logic       sys_clk,
   input  wire logic       sda_line,
   output logic            scl_drv,
   output logic            sda_drv,
   output logic      [7:0] got,
   output logic            got_v
);
   int half = 8;
   // bus idles high; pull-up is modelled by the wired-and at the bench
   initial begin
      scl_drv = 1'b1;
      sda_drv = 1'b1;
      got     = 8'h00;
      got_v   = 1'b0;
   end
   // always move just after an edge so sampling never races
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // one bit time; half >= 8 keeps above the 5-cycle minimum
   task automatic bit_io(input logic b, output logic r);
      sda_drv = b;
      tick(half);
      scl_drv = 1'b1;
      tick(half);
      r = sda_line;
      scl_drv = 1'b0;
      tick(1);
   endtask
   // start and repeated start share one shape
   task automatic start();
      sda_drv = 1'b1;
      tick(half);
      scl_drv = 1'b1;
      tick(half);
      sda_drv = 1'b0;
      tick(half);
      scl_drv = 1'b0;
      tick(half);
   endtask
   task automatic stop();
      sda_drv = 1'b0;
      tick(half);
      scl_drv = 1'b1;
      tick(half);
      sda_drv = 1'b1;
      tick(half);
   endtask
   // msb first, then sample the device ack
   task automatic byte_tx(input logic [7:0] d, output logic nack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, nack);
   endtask
   // nack on the last byte ends the read
   task automatic byte_rx(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(last, r);
      got   = d;
      got_v = 1'b1;
      tick(1);
      got_v = 1'b0;
   endtask
endmodule // psf_host_model
`default_nettype wire

// >>> verif/psf_page_status_fault_bench.sv
`timescale 1ns/1ns
`default_nettype none
module psf_page_status_fault_bench;
   import psf_pkg::*;
   localparam logic [6:0] DEV = PSF_DEV_ADDR_DEFAULT;
   logic       sys_clk = 1'b0;
   logic       nrst    = 1'b0;
   logic       scl_drv;
   logic       sda_drv;
   wire logic  sda_in;
   logic       sda_out;
   logic       sda_oe_n;
   logic       key_n   = 1'b1;
   logic [4:0] gpi     = 5'h00;
   logic       ramp    = 1'b0;
   logic [3:0] oc      = 4'h0;
   logic       ev_wait  = 1'b0;
   logic       ev_rreq  = 1'b0;
   logic       ev_key   = 1'b0;
   logic       ev_temp  = 1'b0;
   logic       ev_start = 1'b0;
   logic       ev_lowuv = 1'b0;
   logic       ev_por   = 1'b0;
   logic       ev_wdg   = 1'b0;
   logic       rst_out_n = 1'b0;
   logic [5:0] page_sel;
   logic [7:0] log_q;
   logic [7:0] got;
   logic       got_v;
   logic [7:0] exp_q[$];
   int         num_errors  = 0;
   int         check_count = 0;
   // open drain: any party pulling low wins
   assign sda_in = sda_drv & (sda_oe_n | sda_out);
   always #2 sys_clk = ~sys_clk;
   psf_page_status_fault #(.DEV_ADDR(DEV), .VDD_START_CYCLES(32'd100)) i_psf_page_status_fault (
      .sys_clk(sys_clk), .nrst(nrst), .scl_in(scl_drv), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .power_key_pin_n(key_n),
      .gpi_pin(gpi), .voltage_ramp_active(ramp), .regulator_overcurrent_flag(oc),
      .wait_step_timeout(ev_wait), .external_reset_request(ev_rreq),
      .power_key_reset(ev_key), .critical_overtemp(ev_temp),
      .system_supply_start_uv(ev_start), .system_supply_lower_uv(ev_lowuv),
      .power_on_start(ev_por), .watchdog_expiry(ev_wdg),
      .system_reset_out_n(rst_out_n), .page_sel(page_sel), .shutdown_cause_log(log_q));
   psf_host_model i_psf_host_model (
      .sys_clk(sys_clk), .sda_line(sda_in), .scl_drv(scl_drv),
      .sda_drv(sda_drv), .got(got), .got_v(got_v));
   task automatic cmp(input logic [7:0] act, input logic [7:0] exp);
      check_count++;
      if (act !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, act, exp);
      end
   endtask
   // read results are matched oldest first against the noted values
   always @(posedge got_v) begin
      cmp(got, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
      logic n;
      i_psf_host_model.start();
      i_psf_host_model.byte_tx({DEV, 1'b0}, n);
      cmp({7'h00, n}, 8'h00);
      i_psf_host_model.byte_tx(a, n);
      foreach (d[i]) i_psf_host_model.byte_tx(d[i], n);
      i_psf_host_model.stop();
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e[$]);
      logic       n;
      logic [7:0] d;
      foreach (e[i]) exp_q.push_back(e[i]);
      i_psf_host_model.start();
      i_psf_host_model.byte_tx({DEV, 1'b0}, n);
      i_psf_host_model.byte_tx(a, n);
      i_psf_host_model.start();
      i_psf_host_model.byte_tx({DEV, 1'b1}, n);
      foreach (e[i]) i_psf_host_model.byte_rx(i == e.size() - 1, d);
      i_psf_host_model.stop();
   endtask
   task automatic pulse(input int i);
      {ev_wait, ev_rreq, ev_key, ev_temp, ev_start, ev_lowuv, ev_por, ev_wdg} = 8'h01 << i;
      i_psf_host_model.tick(1);
      {ev_wait, ev_rreq, ev_key, ev_temp, ev_start, ev_lowuv, ev_por, ev_wdg} = 8'h00;
      i_psf_host_model.tick(3);
   endtask
   task automatic done(input string s);
      $display("test %s done, errors %0d", s, num_errors);
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // hang guard, well beyond the expected run of some 25k cycles
   initial begin
      #(4 * 90000);
      num_errors++;
      $display("watchdog ran out at %0t", $time);
      final_report();
   end
   initial begin
      logic       n;
      logic [7:0] m;
      void'($urandom(51));
      repeat (16) @(posedge sys_clk);
      #1 nrst = 1'b1;
      i_psf_host_model.tick(6);
      cmp({2'b00, page_sel}, 8'h00);
      cmp(log_q, 8'h00);
      cmp({7'h00, sda_oe_n}, 8'h01);
      rd(8'h00, '{8'h00});
      i_psf_host_model.start();
      i_psf_host_model.byte_tx({~DEV, 1'b0}, n);
      cmp({7'h00, n}, 8'h01);
      i_psf_host_model.stop();
      done("reset");
      // live status with random levels, slow host on the second pass
      for (int k = 0; k < 2; k++) begin
         i_psf_host_model.half = 8 + 4 * k;
         key_n = 1'($urandom);
         gpi   = 5'($urandom);
         ramp  = 1'($urandom);
         oc    = 4'($urandom);
         i_psf_host_model.tick(8);
         rd(8'h01, '{{5'h00, ramp, 1'b0, key_n}, {3'h0, gpi}, 8'h00, {4'h0, oc}, 8'h00});
         wr(8'h01, '{8'hFF, 8'hFF});
      end
      i_psf_host_model.half = 8;
      done("status");
      // each cause sets its own bit, sticks, then clears by write-back
      for (int i = 0; i < 8; i++) begin
         m = 8'h01 << i;
         pulse(i);
         i_psf_host_model.tick(20);
         cmp(log_q, m);
         rd(8'h05, '{m});
         wr(8'h05, '{m});
         i_psf_host_model.tick(3);
         cmp(log_q, 8'h00);
      end
      pulse(7);
      pulse(2);
      wr(8'h05, '{8'h04});
      cmp(log_q, 8'h80);
      wr(8'h05, '{8'h80});
      done("fault log");
      // supply drop counts only while reset is held or inside the window after its release
      rst_out_n = 1'b1;
      i_psf_host_model.tick(120);
      pulse(3);
      cmp(log_q, 8'h00);
      rst_out_n = 1'b0;
      i_psf_host_model.tick(2);
      rst_out_n = 1'b1;
      i_psf_host_model.tick(10);
      pulse(3);
      cmp(log_q, 8'h08);
      wr(8'h05, '{8'h08});
      done("window");
      // page select, page bit zero ignored, auto-return
      pulse(1);
      wr(8'h00, '{8'h01});
      rd(8'h05, '{8'h02});
      cmp({2'b00, page_sel}, 8'h01);
      wr(8'h00, '{8'h02});
      rd(8'h05, '{8'h00});
      cmp({2'b00, page_sel}, 8'h02);
      wr(8'h00, '{8'h82});
      rd(8'h00, '{8'h82});
      rd(8'h05, '{8'h00});
      cmp({2'b00, page_sel}, 8'h00);
      done("page");
      // address/data pairs, then incrementing bytes
      wr(8'h00, '{8'h40});
      wr(8'h05, '{8'h02, 8'h00, 8'h02});
      cmp(log_q, 8'h00);
      cmp({2'b00, page_sel}, 8'h02);
      wr(8'h00, '{8'h00});
      pulse(1);
      wr(8'h04, '{8'hFF, 8'h02});
      cmp(log_q, 8'h00);
      rd(8'h04, '{{4'h0, oc}});
      done("write style");
      final_report();
   end
endmodule // psf_page_status_fault_bench
`default_nettype wire
